// [verilog/ocfp_pkg.sv]
// constants and carrier types for the output clock and frame pulse control
package ocfp_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_ENABLE = 4'h0;
  localparam logic [3:0] OFS_SELECT = 4'h4;
  localparam logic [3:0] OFS_MODE = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int EN_PAIR_ZERO = 0;
  localparam int EN_PAIR_ONE = 1;
  localparam int EN_PAIR_TWO = 2;
  localparam int EN_PAIR_THREE = 3;
  localparam int EN_CLOCK_FOUR = 4;
  localparam int EN_CLOCK_FIVE = 5;
  localparam int SEL_CLOCK_TWO_POL = 8;
  localparam int SEL_PAIR_THREE_LO = 12;
  localparam int SEL_PAIR_THREE_HI = 13;
  localparam int SEL_CLOCK_FOUR_RATE = 14;
  localparam int MODE_SLAVE_PLL = 0;
  localparam int ST_MASTER = 0;
  localparam int ST_AVAIL = 1;
  localparam int ST_FIVE_ON = 2;
  localparam int ST_FOUR_ON = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_SELECT = 16'h0000;
  localparam logic [15:0] RST_MODE = 16'h0000;

  // pair three rate codes
  localparam logic [1:0] RATE_4M = 2'h0;
  localparam logic [1:0] RATE_8M = 2'h1;
  localparam logic [1:0] RATE_16M = 2'h2;
  localparam logic [1:0] RATE_32M = 2'h3;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ck_zero;
    logic ck_one;
    logic ck_two;
    logic fp_zero;
    logic fp_one;
    logic fp_two;
    logic ck3_4m;
    logic ck3_8m;
    logic ck3_16m;
    logic ck3_32m;
    logic fp3_244;
    logic fp3_122;
    logic fp3_61;
    logic fp3_30;
    logic ck4_2m;
    logic ck4_1m5;
    logic ck_five;
  } timing_src_t;

  typedef struct packed {
    logic out_clock_five;
    logic out_clock_four;
    logic out_clock_three;
    logic out_clock_two;
    logic out_clock_one;
    logic out_clock_zero;
    logic frame_pulse_three;
    logic frame_pulse_two;
    logic frame_pulse_one;
    logic frame_pulse_zero;
  } pin_bus_t;

  localparam int PIN_W = $bits(pin_bus_t);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

// [verilog/out_drive.sv]
// registered pin drivers with output enables
`timescale 1ns/1ps
module out_drive #(
  parameter int W = 10
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [W-1:0] val_i,
  input wire logic [W-1:0] en_i,
  output logic [W-1:0] out_o,
  output logic [W-1:0] oe_o
);

  // ---------------------------------------------------------------
  // pin registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_o <= '0;
      oe_o <= '0;
    end else if (ce_i) begin
      out_o <= val_i & en_i;
      oe_o <= en_i;
    end
  end

endmodule

// [verilog/output_clock_frame_pulse_ctrl.sv]
// output clock and frame pulse enable, selection and register access
// Operation
// [RULE1] clock five undriven while its enable clear
// [RULE2] enable bit 4 set drives clock four
// [RULE3] enable bit 4 clear floats clock four
// [RULE4] clock five needs master or slave pll
// [RULE5] clock four needs master or slave pll
// [RULE6] bit 3 drives or floats pair three
// [RULE7] bit 2 drives or floats pair two
// [RULE8] bit 1 drives or floats pair one
// [RULE9] bit 0 drives or floats pair zero
// [RULE10] bit 8 picks clock two boundary edge
// [RULE11] bits 13:12 pick pair three rate
// [RULE12] bit 14 picks clock four rate
`timescale 1ns/1ps
module output_clock_frame_pulse_ctrl
  import ocfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic master_mode_i,
  input wire timing_src_t timing_i,
  output pin_bus_t pins_o,
  output pin_bus_t pins_oe_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  bus_state_t state_ff;
  bus_state_t nxt_state;
  logic req;
  logic take;
  logic [15:0] enable_ff;
  logic [15:0] select_ff;
  logic [15:0] mode_ff;
  logic [15:0] status;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;

  assign req = read_i | write_i;
  assign take = req & (state_ff == BUS_IDLE) & ce_i;
  assign waitrequest_o = req & (state_ff != BUS_ACK);
  assign readdata_o = readdata_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BUS_IDLE: begin
        if (req) begin
          nxt_state = BUS_ACK;
        end
      end
      BUS_ACK: begin
        nxt_state = BUS_IDLE;
      end
      default: begin
        nxt_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= BUS_IDLE;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    nxt_readdata = 32'h0000_0000;
    if (address_i == OFS_ENABLE) begin
      nxt_readdata[15:0] = enable_ff;
    end else if (address_i == OFS_SELECT) begin
      nxt_readdata[15:0] = select_ff;
    end else if (address_i == OFS_MODE) begin
      nxt_readdata[15:0] = mode_ff;
    end else if (address_i == OFS_STATUS) begin
      nxt_readdata[15:0] = status;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      readdata_ff <= 32'h0000_0000;
    end else if (take & read_i) begin
      readdata_ff <= nxt_readdata;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      enable_ff <= RST_ENABLE;
    end else if (take & write_i & (address_i == OFS_ENABLE)) begin
      enable_ff <= lane_merge(enable_ff, writedata_i, byteenable_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      select_ff <= RST_SELECT;
    end else if (take & write_i & (address_i == OFS_SELECT)) begin
      select_ff <= lane_merge(select_ff, writedata_i, byteenable_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_ff <= RST_MODE;
    end else if (take & write_i & (address_i == OFS_MODE)) begin
      mode_ff <= lane_merge(mode_ff, writedata_i, byteenable_i);
    end
  end

  // ---------------------------------------------------------------
  // clock selection and enables
  // ---------------------------------------------------------------
  logic avail;
  logic [1:0] rate3;
  logic ck3_sel;
  logic fp3_sel;
  pin_bus_t val;
  pin_bus_t en;

  assign avail = master_mode_i | mode_ff[MODE_SLAVE_PLL]; // RULE4 RULE5
  assign rate3 = select_ff[SEL_PAIR_THREE_HI:SEL_PAIR_THREE_LO];

  always_comb begin
    case (rate3) // RULE11
      RATE_4M: begin
        ck3_sel = timing_i.ck3_4m;
        fp3_sel = timing_i.fp3_244;
      end
      RATE_8M: begin
        ck3_sel = timing_i.ck3_8m;
        fp3_sel = timing_i.fp3_122;
      end
      RATE_16M: begin
        ck3_sel = timing_i.ck3_16m;
        fp3_sel = timing_i.fp3_61;
      end
      default: begin
        ck3_sel = timing_i.ck3_32m;
        fp3_sel = timing_i.fp3_30;
      end
    endcase
  end

  always_comb begin
    val.out_clock_five = timing_i.ck_five;
    val.out_clock_four = select_ff[SEL_CLOCK_FOUR_RATE] ? // RULE12
                         timing_i.ck4_1m5 : timing_i.ck4_2m;
    val.out_clock_three = ck3_sel;
    val.out_clock_two = select_ff[SEL_CLOCK_TWO_POL] ? // RULE10
                        timing_i.ck_two : ~timing_i.ck_two;
    val.out_clock_one = timing_i.ck_one;
    val.out_clock_zero = timing_i.ck_zero;
    val.frame_pulse_three = fp3_sel;
    val.frame_pulse_two = timing_i.fp_two;
    val.frame_pulse_one = timing_i.fp_one;
    val.frame_pulse_zero = timing_i.fp_zero;
  end

  always_comb begin
    en.out_clock_five = enable_ff[EN_CLOCK_FIVE] & avail; // RULE1 RULE4
    en.out_clock_four = enable_ff[EN_CLOCK_FOUR] & avail; // RULE2 RULE3 RULE5
    en.out_clock_three = enable_ff[EN_PAIR_THREE]; // RULE6
    en.frame_pulse_three = enable_ff[EN_PAIR_THREE]; // RULE6
    en.out_clock_two = enable_ff[EN_PAIR_TWO]; // RULE7
    en.frame_pulse_two = enable_ff[EN_PAIR_TWO]; // RULE7
    en.out_clock_one = enable_ff[EN_PAIR_ONE]; // RULE8
    en.frame_pulse_one = enable_ff[EN_PAIR_ONE]; // RULE8
    en.out_clock_zero = enable_ff[EN_PAIR_ZERO]; // RULE9
    en.frame_pulse_zero = enable_ff[EN_PAIR_ZERO]; // RULE9
  end

  out_drive #(
    .W(PIN_W)
  ) u_drive (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .val_i(val),
    .en_i(en),
    .out_o(pins_o),
    .oe_o(pins_oe_o)
  );

  always_comb begin
    status = 16'h0000;
    status[ST_MASTER] = master_mode_i;
    status[ST_AVAIL] = avail;
    status[ST_FIVE_ON] = pins_oe_o.out_clock_five;
    status[ST_FOUR_ON] = pins_oe_o.out_clock_four;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_five_off;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && !enable_ff[EN_CLOCK_FIVE] |=>
      !pins_oe_o.out_clock_five && !pins_o.out_clock_five;
  endproperty
  a_five_off: assert property (p_five_off) // RULE1
    else $error("clock five driven while disabled");

  property p_four_on;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && enable_ff[EN_CLOCK_FOUR] && avail |=>
      pins_oe_o.out_clock_four &&
      pins_o.out_clock_four == $past(val.out_clock_four);
  endproperty
  a_four_on: assert property (p_four_on) // RULE2
    else $error("clock four not driven while enabled");

  property p_four_off;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && !enable_ff[EN_CLOCK_FOUR] |=> !pins_oe_o.out_clock_four;
  endproperty
  a_four_off: assert property (p_four_off) // RULE3
    else $error("clock four driven while disabled");

  property p_five_avail;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && !master_mode_i && !mode_ff[MODE_SLAVE_PLL] |=>
      !pins_oe_o.out_clock_five;
  endproperty
  a_five_avail: assert property (p_five_avail) // RULE4
    else $error("clock five driven while unavailable");

  property p_four_avail;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && enable_ff[EN_CLOCK_FOUR] |=>
      pins_oe_o.out_clock_four == $past(avail);
  endproperty
  a_four_avail: assert property (p_four_avail) // RULE5
    else $error("clock four availability mismatch");

  property p_pair_three;
    @(posedge clk_i) disable iff (reset_i)
    ce_i |=> pins_oe_o.out_clock_three == $past(enable_ff[EN_PAIR_THREE])
      && pins_oe_o.frame_pulse_three == pins_oe_o.out_clock_three;
  endproperty
  a_pair_three: assert property (p_pair_three) // RULE6
    else $error("pair three enable mismatch");

  property p_pair_two;
    @(posedge clk_i) disable iff (reset_i)
    ce_i |=> pins_oe_o.out_clock_two == $past(enable_ff[EN_PAIR_TWO])
      && pins_oe_o.frame_pulse_two == pins_oe_o.out_clock_two;
  endproperty
  a_pair_two: assert property (p_pair_two) // RULE7
    else $error("pair two enable mismatch");

  property p_pair_one;
    @(posedge clk_i) disable iff (reset_i)
    ce_i |=> pins_oe_o.out_clock_one == $past(enable_ff[EN_PAIR_ONE])
      && pins_oe_o.frame_pulse_one == pins_oe_o.out_clock_one;
  endproperty
  a_pair_one: assert property (p_pair_one) // RULE8
    else $error("pair one enable mismatch");

  property p_pair_zero;
    @(posedge clk_i) disable iff (reset_i)
    ce_i |=> pins_oe_o.out_clock_zero == $past(enable_ff[EN_PAIR_ZERO])
      && pins_oe_o.frame_pulse_zero == pins_oe_o.out_clock_zero;
  endproperty
  a_pair_zero: assert property (p_pair_zero) // RULE9
    else $error("pair zero enable mismatch");

  property p_two_pol;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && enable_ff[EN_PAIR_TWO] |=>
      pins_o.out_clock_two ==
      ($past(timing_i.ck_two) ~^ $past(select_ff[SEL_CLOCK_TWO_POL]));
  endproperty
  a_two_pol: assert property (p_two_pol) // RULE10
    else $error("clock two polarity wrong");

  property p_three_rate;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && enable_ff[EN_PAIR_THREE] && rate3 == RATE_16M |=>
      pins_o.out_clock_three == $past(timing_i.ck3_16m) &&
      pins_o.frame_pulse_three == $past(timing_i.fp3_61);
  endproperty
  a_three_rate: assert property (p_three_rate) // RULE11
    else $error("pair three rate wrong");

  property p_three_slow;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && enable_ff[EN_PAIR_THREE] && rate3 == RATE_4M |=>
      pins_o.out_clock_three == $past(timing_i.ck3_4m) &&
      pins_o.frame_pulse_three == $past(timing_i.fp3_244);
  endproperty
  a_three_slow: assert property (p_three_slow) // RULE11
    else $error("pair three slowest rate wrong");

  property p_three_fast;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && enable_ff[EN_PAIR_THREE] && rate3 == RATE_32M |=>
      pins_o.out_clock_three == $past(timing_i.ck3_32m) &&
      pins_o.frame_pulse_three == $past(timing_i.fp3_30);
  endproperty
  a_three_fast: assert property (p_three_fast) // RULE11
    else $error("pair three fastest rate wrong");

  property p_five_on;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && enable_ff[EN_CLOCK_FIVE] && avail |=>
      pins_oe_o.out_clock_five &&
      pins_o.out_clock_five == $past(timing_i.ck_five);
  endproperty
  a_five_on: assert property (p_five_on) // RULE4
    else $error("clock five not driven while available");

  property p_four_rate;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && en.out_clock_four && select_ff[SEL_CLOCK_FOUR_RATE] |=>
      pins_o.out_clock_four == $past(timing_i.ck4_1m5);
  endproperty
  a_four_rate: assert property (p_four_rate) // RULE12
    else $error("clock four rate wrong");

endmodule

// [sim/tdm_sink.sv]
// far side model: external tdm devices seeing the generated pins
`timescale 1ns/1ps
module tdm_sink
  import ocfp_pkg::*;
(
  input wire logic clk_i,
  input wire pin_bus_t pins_i,
  input wire pin_bus_t oe_i,
  output pin_bus_t line_o
);
  // ---------------------------------------------------------------
  // wire level: driven value, else the inverse of the last level
  // ---------------------------------------------------------------
  pin_bus_t last_ff = '0;
  always_ff @(posedge clk_i) begin
    last_ff <= line_o;
  end
  always_comb begin
    line_o = (pins_i & oe_i) | (~last_ff & ~oe_i);
  end
endmodule

// [sim/output_clock_frame_pulse_ctrl_test.sv]
// self-checking bench for the output clock and frame pulse control
`timescale 1ns/1ps
module output_clock_frame_pulse_ctrl_test;
  import ocfp_pkg::*;
  logic clk_i, reset_i, ce_i, read_i, write_i, master_mode_i;
  logic [3:0] address_i, byteenable_i;
  logic [31:0] writedata_i, readdata_o, q;
  logic waitrequest_o;
  timing_src_t timing_i;
  pin_bus_t pins_o, pins_oe_o, line, ev, eo, held;
  logic [15:0] regs_m [3];
  int n_errors, cmp_count, cyc, k;

  output_clock_frame_pulse_ctrl dut (.clk_i(clk_i), .reset_i(reset_i),
    .ce_i(ce_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .master_mode_i(master_mode_i), .timing_i(timing_i), .pins_o(pins_o),
    .pins_oe_o(pins_oe_o));
  tdm_sink sink (.clk_i(clk_i), .pins_i(pins_o), .oe_i(pins_oe_o),
    .line_o(line));

  // ---------------------------------------------------------------
  // clock, timeout, verdict
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // compare tasks
  // ---------------------------------------------------------------
  task automatic cmp_reg(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_pins(string nm, pin_bus_t e, pin_bus_t g);
    cmp_count++;
    if (e !== g) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ---------------------------------------------------------------
  // model of the pins from registers and sources
  // ---------------------------------------------------------------
  task automatic model_pins(timing_src_t t);
    logic [15:0] e, s;
    logic av;
    e = regs_m[0];
    s = regs_m[1];
    av = master_mode_i | regs_m[2][0];
    eo = {e[5] & av, e[4] & av, e[3], e[2], e[1], e[0],
      e[3], e[2], e[1], e[0]};
    ev.out_clock_five = t.ck_five;
    ev.out_clock_four = s[14] ? t.ck4_1m5 : t.ck4_2m;
    case (s[13:12])
      2'h0: {ev.out_clock_three, ev.frame_pulse_three} = {t.ck3_4m, t.fp3_244};
      2'h1: {ev.out_clock_three, ev.frame_pulse_three} = {t.ck3_8m, t.fp3_122};
      2'h2: {ev.out_clock_three, ev.frame_pulse_three} = {t.ck3_16m, t.fp3_61};
      default: {ev.out_clock_three, ev.frame_pulse_three} =
        {t.ck3_32m, t.fp3_30};
    endcase
    ev.out_clock_two = s[8] ? t.ck_two : ~t.ck_two;
    ev.out_clock_one = t.ck_one;
    ev.out_clock_zero = t.ck_zero;
    ev.frame_pulse_two = t.fp_two;
    ev.frame_pulse_one = t.fp_one;
    ev.frame_pulse_zero = t.fp_zero;
    ev = ev & eo;
  endtask

  // ---------------------------------------------------------------
  // avalon master: hold until waitrequest sampled low
  // ---------------------------------------------------------------
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d,
    logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    if (wr) write_i <= 1'b1;
    else read_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    q = readdata_o;
    if (n >= 50) n_errors++;
    write_i <= 1'b0;
    read_i <= 1'b0;
    if (wr && a[1:0] == 2'h0 && a[3:2] != 2'h3) begin
      if (be[0]) regs_m[a[3:2]][7:0] = d[7:0];
      if (be[1]) regs_m[a[3:2]][15:8] = d[15:8];
    end
  endtask
  task automatic chk_read(logic [3:0] a);
    logic [31:0] e;
    e = '0;
    if (a == OFS_STATUS) begin
      model_pins(timing_i);
      e[3:0] = {eo.out_clock_four, eo.out_clock_five,
        master_mode_i | regs_m[2][0], master_mode_i};
    end else if (a[1:0] == 2'h0) e[15:0] = regs_m[a[3:2]];
    bus(1'b0, a, '0, 4'h0);
    cmp_reg("readdata", e, q);
  endtask
  task automatic chk_pins(int n);
    repeat (n) begin
      @(posedge clk_i);
      timing_i <= timing_src_t'(17'($urandom));
      @(posedge clk_i);
      #1;
      model_pins(timing_i);
      cmp_pins("pins", ev, pins_o);
      cmp_pins("pins_oe", eo, pins_oe_o);
      cmp_pins("line", ev & eo, line & eo);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset_i, ce_i} = 2'b11;
    {read_i, write_i, master_mode_i} = 3'b000;
    {address_i, byteenable_i, writedata_i} = '0;
    timing_i = '0;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    for (k = 0; k < 3; k++) regs_m[k] = '0;
    void'($urandom(32'h17fa));
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    chk_pins(2);
    for (k = 0; k < 4; k++) chk_read(4'(k * 4));
    bus(1'b1, 4'h2, 32'hffff, 4'hf);
    chk_read(4'h2);
    chk_read(4'h0);
    $display("reset and map test done");
    for (k = 0; k < 40; k++) begin
      master_mode_i <= (k % 3 == 0);
      bus(1'b1, OFS_ENABLE, (k < 6) ? (1 << k) : $urandom, 4'h3);
      bus(1'b1, OFS_SELECT, {17'($urandom), k[3], k[1:0], 3'($urandom),
        k[2], 8'($urandom)}, 4'(k < 20 ? 3 : $urandom));
      bus(1'b1, OFS_MODE, k[4], 4'h1);
      chk_pins(3);
      chk_read(OFS_STATUS);
      chk_read(OFS_SELECT);
    end
    $display("enable and select test done");
    @(posedge clk_i);
    ce_i <= 1'b0;
    @(posedge clk_i);
    held = pins_o;
    timing_i <= ~timing_i;
    repeat (3) @(posedge clk_i);
    cmp_pins("frozen", held, pins_o);
    ce_i <= 1'b1;
    chk_pins(2);
    $display("clock enable test done");
    end_sim();
  end
endmodule
